// [core/scr_defines.svh]
// Register offsets, field positions, reset values and codes for the status clock router
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH
`define SCR_ROUTE_CTRL_ADDR   8'h2d
`define SCR_DIV_A_ADDR        8'h2e
`define SCR_DIV_B_ADDR        8'h2f
`define SCR_PRE_B_MSB         7
`define SCR_PRE_B_LSB         6
`define SCR_PRE_A_MSB         5
`define SCR_PRE_A_LSB         4
`define SCR_PIN_B_MSB         3
`define SCR_PIN_B_LSB         2
`define SCR_PIN_A_MSB         1
`define SCR_PIN_A_LSB         0
`define SCR_ROUTE_CTRL_RESET  8'h0a
`define SCR_DIV_RESET         8'h00
`define SCR_PRE_DIV4          3'h4
`define SCR_PRE_DIV5          3'h5
`define SCR_DIV_MIN_CODE      8'h05
`define SCR_DIV_MIN_RATIO     9'h006
`endif

// [core/scr_pkg.sv]
// Types shared by the status clock router
package scr_pkg;
    typedef enum logic [1:0] {
        SCR_PRE_OFF  = 2'h0,
        SCR_PRE_4    = 2'h1,
        SCR_PRE_5    = 2'h2,
        SCR_PRE_RSVD = 2'h3
    } scr_pre_sel_t;
    typedef enum logic [1:0] {
        SCR_SRC_DIV_A  = 2'h0,
        SCR_SRC_DIV_B  = 2'h1,
        SCR_SRC_STATUS = 2'h2,
        SCR_SRC_OFF    = 2'h3
    } scr_pin_sel_t;
    typedef struct packed {
        scr_pre_sel_t pre_b;
        scr_pre_sel_t pre_a;
        scr_pin_sel_t pin_b;
        scr_pin_sel_t pin_a;
    } scr_route_ctrl_t;
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scr_reg_req_t;
endpackage

// [core/scr_clk_div.sv]
// Enable-pulse divider chain: prescale then programmable CMOS divider
`timescale 1ns/100ps
`default_nettype none
`include "scr_defines.svh"
module scr_clk_div (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              src_en,
    input  wire scr_pkg::scr_pre_sel_t pre_sel,
    input  wire logic [7:0]        div_code,
    output logic                   clk_out
);
    logic [2:0] pre_cnt_q;
    logic       pre_en;
    logic [2:0] pre_ratio;
    logic [8:0] ratio;
    logic [8:0] div_cnt_q;

    // Prescale ratio; reserved code behaves as off
    always_comb begin
        unique case (pre_sel)
            scr_pkg::SCR_PRE_4: pre_ratio = `SCR_PRE_DIV4;
            scr_pkg::SCR_PRE_5: pre_ratio = `SCR_PRE_DIV5;
            default:            pre_ratio = 3'h0;
        endcase
    end

    // Prescaler produces one enable per ratio source edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_cnt_q <= 3'h0;
        end else if (pre_ratio == 3'h0) begin
            pre_cnt_q <= 3'h0;
        end else if (src_en) begin
            pre_cnt_q <= (pre_cnt_q >= pre_ratio - 3'h1) ? 3'h0 : pre_cnt_q + 3'h1;
        end
    end
    assign pre_en = src_en && (pre_ratio != 3'h0) && (pre_cnt_q >= pre_ratio - 3'h1);

    // Codes 1..5 clamp to /6, code n above gives n+1
    assign ratio = (div_code <= `SCR_DIV_MIN_CODE) ? `SCR_DIV_MIN_RATIO
                                                 : {1'b0, div_code} + 9'h001;

    // Output toggles at half-period counts; odd ratios get a slightly uneven duty
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_q <= 9'h000;
            clk_out   <= 1'b0;
        end else if (div_code == 8'h00 || pre_ratio == 3'h0) begin
            div_cnt_q <= 9'h000;
            clk_out   <= 1'b0;
        end else if (pre_en) begin
            if (div_cnt_q >= ratio - 9'h001) begin
                div_cnt_q <= 9'h000;
                clk_out   <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 9'h001;
                if (div_cnt_q + 9'h001 == {1'b0, ratio[8:1]}) begin
                    clk_out <= 1'b0;
                end
            end
        end
    end
endmodule // scr_clk_div
`default_nettype wire

// [core/scr_router.sv]
// Status pin clock router with its control and divider registers
`timescale 1ns/100ps
`default_nettype none
`include "scr_defines.svh"
// Functional notes
// - Bits 7:6 pick second prescaler: off, /4, /5, reserved.
// - Bits 5:4 pick first prescaler: off, /4, /5, reserved.
// - Both prescaler fields reset to zero, prescalers disabled.
// - Bits 3:2 route pin B: divider A, divider B, status, off.
// - Bits 1:0 route pin A the same way; resets to status.
// - Each pin picks either divider independently of the other.
// - Divider A follows first prescaler, divider B follows second.
// - Divider code 0 off, 1..5 give /6, n gives /(n+1).
module scr_router (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire scr_pkg::scr_reg_req_t reg_req,
    input  wire logic                  synth_a_en,
    input  wire logic                  synth_b_en,
    input  wire logic                  status_a,
    input  wire logic                  status_b,
    output logic [7:0]                 reg_rdata,
    output logic                       aux_pin_a,
    output logic                       aux_pin_a_oe_b,
    output logic                       aux_pin_b,
    output logic                       aux_pin_b_oe_b
);
    scr_pkg::scr_route_ctrl_t cmos_clock_route_control_q;
    logic [7:0]               cmos_divider_a_q;
    logic [7:0]               cmos_divider_b_q;
    logic [1:0]               synth_en;
    logic [1:0]               status_in;
    scr_pkg::scr_pre_sel_t    pre_sel [2];
    scr_pkg::scr_pin_sel_t    pin_sel [2];
    logic [7:0]               div_code [2];
    logic [1:0]               div_clk;
    logic [1:0]               pin_q;
    logic [1:0]               pin_oe_b_q;

    // Register writes; fields come up disabled, pins on status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmos_clock_route_control_q <= scr_pkg::scr_route_ctrl_t'(`SCR_ROUTE_CTRL_RESET);
            cmos_divider_a_q           <= `SCR_DIV_RESET;
            cmos_divider_b_q           <= `SCR_DIV_RESET;
        end else if (reg_req.wr_en) begin
            unique case (reg_req.addr)
                `SCR_ROUTE_CTRL_ADDR: cmos_clock_route_control_q <=
                    scr_pkg::scr_route_ctrl_t'(reg_req.wdata);
                `SCR_DIV_A_ADDR:      cmos_divider_a_q <= reg_req.wdata;
                `SCR_DIV_B_ADDR:      cmos_divider_b_q <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // Registered readback; unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_req.addr)
                `SCR_ROUTE_CTRL_ADDR: reg_rdata <= cmos_clock_route_control_q;
                `SCR_DIV_A_ADDR:      reg_rdata <= cmos_divider_a_q;
                `SCR_DIV_B_ADDR:      reg_rdata <= cmos_divider_b_q;
                default:              reg_rdata <= 8'h00;
            endcase
        end
    end

    // Channel 0 is pin A with divider A, channel 1 pin B with divider B
    assign synth_en    = {synth_b_en, synth_a_en};
    assign status_in   = {status_b, status_a};
    assign pre_sel[0]  = cmos_clock_route_control_q.pre_a;
    assign pre_sel[1]  = cmos_clock_route_control_q.pre_b;
    assign pin_sel[0]  = cmos_clock_route_control_q.pin_a;
    assign pin_sel[1]  = cmos_clock_route_control_q.pin_b;
    assign div_code[0] = cmos_divider_a_q;
    assign div_code[1] = cmos_divider_b_q;

    // One channel per pin: status sync, divider chain, source select
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            logic [1:0] stat_s_q;

            // Status flags come from other logic; synchronise before use
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    stat_s_q <= 2'h0;
                end else begin
                    stat_s_q <= {stat_s_q[0], status_in[ch]};
                end
            end

            // Divider A rides the first synth, divider B the second
            scr_clk_div u_div (
                .clk      (clk),
                .rst_b    (rst_b),
                .src_en   (synth_en[ch]),
                .pre_sel  (pre_sel[ch]),
                .div_code (div_code[ch]),
                .clk_out  (div_clk[ch])
            );

            // Either pin may take either divider; registered so pins leave flops
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    pin_q[ch]      <= 1'b0;
                    pin_oe_b_q[ch] <= 1'b0;
                end else begin
                    pin_oe_b_q[ch] <= 1'b0;
                    unique case (pin_sel[ch])
                        scr_pkg::SCR_SRC_DIV_A:  pin_q[ch] <= div_clk[0];
                        scr_pkg::SCR_SRC_DIV_B:  pin_q[ch] <= div_clk[1];
                        scr_pkg::SCR_SRC_STATUS: pin_q[ch] <= stat_s_q[1];
                        scr_pkg::SCR_SRC_OFF: begin
                            pin_q[ch]      <= 1'b0; // Low as well as released
                            pin_oe_b_q[ch] <= 1'b1;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Pins come straight from the channel flops
    assign aux_pin_a      = pin_q[0];
    assign aux_pin_a_oe_b = pin_oe_b_q[0];
    assign aux_pin_b      = pin_q[1];
    assign aux_pin_b_oe_b = pin_oe_b_q[1];
endmodule // scr_router
`default_nettype wire

// [tb/scr_router_assertions.sv]
// Port-level assertions for the status pin clock router
`timescale 1ns/100ps
`default_nettype none
module scr_router_chk (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire scr_pkg::scr_reg_req_t reg_req,
    input wire logic                  status_a,
    input wire logic                  status_b,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  aux_pin_a,
    input wire logic                  aux_pin_a_oe_b,
    input wire logic                  aux_pin_b,
    input wire logic                  aux_pin_b_oe_b
);
    logic [7:0] ctl_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Shadow of the control byte, as only ports are visible here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) ctl_q <= 8'h0a;
        else if (reg_req.wr_en && reg_req.addr == 8'h2d) ctl_q <= reg_req.wdata;
    end
    // Write, then hold the address for the registered readback
    sequence s_wr_hold;
        reg_req.wr_en && reg_req.addr inside {8'h2d, 8'h2e, 8'h2f} ##1
            !reg_req.wr_en && $stable(reg_req.addr);
    endsequence
    // Pin on a divider whose prescaler is off or reserved
    sequence s_a_dark;
        (ctl_q[5] == ctl_q[4] && ctl_q[1:0] == 2'h0) [*3];
    endsequence
    sequence s_b_dark;
        (ctl_q[7] == ctl_q[6] && ctl_q[3:2] == 2'h1) [*3];
    endsequence
    AST_READBACK: assert property (
        s_wr_hold |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("bad readback");
    AST_UNMAPPED: assert property (
        !(reg_req.addr inside {8'h2d, 8'h2e, 8'h2f}) |=> reg_rdata == 8'h00) else $error("bad hole");
    AST_PIN_A_OFF: assert property (
        ctl_q[1:0] == 2'h3 |=> aux_pin_a_oe_b && !aux_pin_a) else $error("pin a not off");
    AST_PIN_A_ON: assert property (
        ctl_q[1:0] != 2'h3 |=> !aux_pin_a_oe_b) else $error("pin a not driven");
    AST_PIN_B_OFF: assert property (
        ctl_q[3:2] == 2'h3 |=> aux_pin_b_oe_b && !aux_pin_b) else $error("pin b not off");
    AST_PIN_B_ON: assert property (
        ctl_q[3:2] != 2'h3 |=> !aux_pin_b_oe_b) else $error("pin b not driven");
    AST_STATUS_B: assert property (
        (ctl_q[3:2] == 2'h2) [*4] |-> aux_pin_b == $past(status_b, 3)) else $error("bad status b");
    AST_STATUS_A: assert property (
        (ctl_q[1:0] == 2'h2) [*4] |-> aux_pin_a == $past(status_a, 3)) else $error("bad status");
    AST_DARK_A: assert property (
        s_a_dark |=> !aux_pin_a) else $error("pin a clocked");
    AST_DARK_B: assert property (
        s_b_dark |=> !aux_pin_b) else $error("pin b clocked");
endmodule // scr_router_chk
bind scr_router scr_router_chk u_chk (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
    .status_a(status_a), .status_b(status_b), .reg_rdata(reg_rdata), .aux_pin_a(aux_pin_a),
    .aux_pin_a_oe_b(aux_pin_a_oe_b), .aux_pin_b(aux_pin_b), .aux_pin_b_oe_b(aux_pin_b_oe_b));
`default_nettype wire

// [tb/scr_pin_sink.sv]
// Downstream sink model timing the rises on one status pin
`timescale 1ns/100ps
`default_nettype none
module scr_pin_sink (
    input  wire logic   clk,
    input  wire logic   rst_b,
    input  wire logic   pin,
    input  wire logic   pin_oe_b,
    output logic [15:0] period,
    output logic [7:0]  rises
);
    logic        last_q;
    logic [15:0] cnt_q;
    // Released pin reads low, as a pull-down would leave it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= 1'b0;
            cnt_q  <= 16'h0001;
            period <= 16'h0000;
            rises  <= 8'h00;
        end else begin
            last_q <= pin & ~pin_oe_b;
            cnt_q  <= cnt_q + 16'h0001;
            if (pin & ~pin_oe_b & ~last_q) begin
                period <= cnt_q;
                cnt_q  <= 16'h0001;
                rises  <= rises + 8'h01;
            end
        end
    end
endmodule // scr_pin_sink
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the status pin clock router
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  syn = 1'b0;
    logic                  syn_b = 1'b0;
    logic                  st_a = 1'b0;
    logic                  st_b = 1'b0;
    scr_pkg::scr_reg_req_t req = '0;
    logic [7:0]            rdata;
    logic                  pa, pa_oe_b, pb, pb_oe_b;
    logic [15:0]           per_a, per_b, ea, eb;
    logic [7:0]            ris_a, ris_b;
    int                    num_errors = 0;
    int                    compares = 0;
    int                    cyc = 0;
    // Control, divider A, divider B for each clock case
    logic [7:0] tbl [3][3] = '{'{8'h94, 8'h01, 8'h06}, '{8'h91, 8'h05, 8'hff},
                               '{8'h64, 8'h06, 8'h05}};
    // Control bytes that must leave both pins without edges
    logic [7:0] dark [2] = '{8'hc4, 8'h14};
    scr_router u_dut (.clk(clk), .rst_b(rst_b), .reg_req(req), .synth_a_en(syn),
        .synth_b_en(syn_b), .status_a(st_a), .status_b(st_b), .reg_rdata(rdata),
        .aux_pin_a(pa), .aux_pin_a_oe_b(pa_oe_b), .aux_pin_b(pb), .aux_pin_b_oe_b(pb_oe_b));
    scr_pin_sink u_sink_a (.clk(clk), .rst_b(rst_b), .pin(pa), .pin_oe_b(pa_oe_b),
        .period(per_a), .rises(ris_a));
    scr_pin_sink u_sink_b (.clk(clk), .rst_b(rst_b), .pin(pb), .pin_oe_b(pb_oe_b),
        .period(per_b), .rises(ris_b));
    initial forever #20 clk = ~clk;
    // Synth A edges every 2nd cycle, B every 3rd; cycle ceiling guards a hang
    always @(posedge clk) begin
        syn <= ~syn;
        syn_b <= (cyc % 3 == 2);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            end_sim;
        end
    end
    // Expected pin period in cycles for select bit sel
    function automatic logic [15:0] expp(logic [7:0] c, logic sel, logic [7:0] da, db);
        logic [1:0] p;
        logic [7:0] d;
        p = sel ? c[7:6] : c[5:4];
        d = sel ? db : da;
        return (sel ? 16'h3 : 16'h2) * (p == 2'h1 ? 16'h4 : 16'h5) *
               (d <= 8'h05 ? 16'h6 : {8'h00, d} + 16'h1);
    endfunction
    task automatic chk(input string nm, input logic [15:0] exp, got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        req <= '{1'b1, a, d};
        @(posedge clk);
        req.wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk);
        req <= '{1'b0, a, 8'h00};
        repeat (2) @(posedge clk);
        #1 chk("reg_rdata", {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h2d, 8'h0a);
        rd(8'h2f, 8'h00);
        rd(8'h30, 8'h00);
        $display("reset test done");
        // Long wait lets an old divider count run out
        for (int i = 0; i < 3; i++) begin
            wr(8'h2e, tbl[i][1]);
            wr(8'h2f, tbl[i][2]);
            wr(8'h2d, tbl[i][0]);
            rd(8'h2d, tbl[i][0]);
            ea = expp(tbl[i][0], tbl[i][0][0], tbl[i][1], tbl[i][2]);
            eb = expp(tbl[i][0], tbl[i][0][2], tbl[i][1], tbl[i][2]);
            repeat (3 * (ea > eb ? ea : eb) + 2600) @(posedge clk);
            chk("period_a", ea, per_a);
            chk("period_b", eb, per_b);
        end
        $display("clock test done");
        // Divider A code 0, reserved and off prescalers: no edges at all
        wr(8'h2e, 8'h00);
        foreach (dark[j]) begin
            wr(8'h2d, dark[j]);
            repeat (20) @(posedge clk);
            ea = {ris_a, ris_b};
            repeat (300) @(posedge clk);
            chk("rises", ea, {ris_a, ris_b});
        end
        st_a <= 1'b1;
        wr(8'h2d, 8'h0a);
        repeat (5) @(posedge clk);
        #1 chk("pins", 16'h0002, {14'h0, pa, pb});
        // Swap the levels so each pin must show its own status input
        @(posedge clk);
        st_a <= 1'b0;
        st_b <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk("pins", 16'h0001, {14'h0, pa, pb});
        wr(8'h2d, 8'h0f);
        repeat (3) @(posedge clk);
        #1 chk("pins_oe_b", 16'h0003, {14'h0, pa_oe_b, pb_oe_b});
        $display("route test done");
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
